// ### pwm_defines.vh
// Purpose: Shared constants for the PWM generator channel control block
// Assumes: APB byte addresses, 32-bit data, 16-bit registers in the low half; the count register adds its down bit at bit 16
// Notes: Included by every design file of the block
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH

`define ADDR_W 12
`define DATA_W 32
`define REG_W 16

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_CONFIG 12'h004
`define OFS_PERIOD 12'h008
`define OFS_MASTER_DUTY 12'h00C
`define OFS_CHANNEL_DUTY 12'h010
`define OFS_DEAD_TIME 12'h014
`define OFS_ALT_DEAD_TIME 12'h018
`define OFS_PHASE 12'h01C
`define OFS_IRQ_STATUS 12'h020
`define OFS_IRQ_MASK 12'h024
`define OFS_COUNT 12'h028

// Buffered value indices
`define IDX_PERIOD 0
`define IDX_MASTER_DUTY 1
`define IDX_CHANNEL_DUTY 2
`define IDX_DEAD_TIME 3
`define IDX_ALT_DEAD_TIME 4
`define IDX_PHASE 5
`define NUM_VALUES 6

// Control register fields
`define CTL_IUE 0
`define CTL_EXT_PERIOD_RESET_EN 1
`define CTL_CAM 2
`define CTL_TBS 3
`define CTL_POL 5
`define CTL_DTM_LO 6
`define CTL_DTM_HI 7
`define CTL_WMASK 16'h00EF
`define CTL_RESET 16'h0000

// Configuration register fields
`define CFG_ON 0
`define CFG_ITB 1
`define CFG_CURRENT_LIMIT_MODE 2
`define CFG_WMASK 16'h0007

// Interrupt bits
`define IRQ_BOUNDARY 0
`define IRQ_EXT_RESET 1
`define IRQ_W 2

// Dead-time modes
`define DTM_POSITIVE 2'b00
`define DTM_NEGATIVE 2'b01
`define DTM_OFF 2'b10
`define DTM_COMP 2'b11

`define ZERO16 16'h0000
`define ONE16 16'h0001
`define ZERO32 32'h0000_0000

`endif

// ### pwm_time_base.v
// Purpose: Local time-base counter with edge or center alignment
// Assumes: tick marks one count step of the selected master base
// Notes: restart loads the phase value and flags a period boundary
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module pwm_time_base (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire run,
	input wire tick,
	input wire restart,
	input wire center,
	input wire [15:0] period,
	input wire [15:0] phase,
	// Status
	output reg [15:0] count,
	output reg down,
	output reg boundary
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `ZERO16;
			down <= 1'b0;
			boundary <= 1'b0;
		end else if (!run) begin
			count <= `ZERO16;
			down <= 1'b0;
			boundary <= 1'b0;
		end else if (restart) begin
			count <= phase;
			down <= 1'b0;
			boundary <= 1'b1;
		end else if (tick && center) begin
			// Up to the period then back down; boundary at the valley
			if (!down) begin
				if (count >= period) begin
					down <= 1'b1;
					count <= (period == `ZERO16) ? `ZERO16 : period - `ONE16;
				end else begin
					count <= count + `ONE16;
				end
				boundary <= 1'b0;
			end else if (count == `ZERO16) begin
				down <= 1'b0;
				count <= `ONE16;
				boundary <= 1'b1;
			end else begin
				count <= count - `ONE16;
				boundary <= 1'b0;
			end
		end else if (tick) begin
			down <= 1'b0;
			if (count >= period) begin
				count <= `ZERO16;
				boundary <= 1'b1;
			end else begin
				count <= count + `ONE16;
				boundary <= 1'b0;
			end
		end else begin
			boundary <= 1'b0;
		end
	end
endmodule // pwm_time_base
`default_nettype wire

// ### pwm_dead_time.v
// Purpose: Turns the raw PWM level into the high/low output pair
// Assumes: delays count in clock cycles since the last raw edge
// Notes: outputs are registered; both are low while the channel is off
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module pwm_dead_time (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire run,
	input wire raw,
	input wire [1:0] mode,
	input wire polarity,
	input wire comp_input,
	input wire [15:0] dead_time,
	input wire [15:0] alt_dead_time,
	// Pins
	output reg out_high,
	output reg out_low
);
	reg raw_prev;
	reg [15:0] since_edge;
	reg [15:0] delay_high;
	reg [15:0] delay_low;
	reg next_high;
	reg next_low;
	wire shorten_high;
	wire [15:0] reduced;
	wire [16:0] sum;
	wire changed;
	wire [15:0] elapsed;

	// Polarity one: input low shortens low; polarity zero: input low shortens high
	assign shorten_high = ~(polarity ^ comp_input);
	assign sum = {1'b0, dead_time} + {1'b0, alt_dead_time};
	assign reduced = (dead_time > alt_dead_time) ? dead_time - alt_dead_time : `ZERO16;
	// The edge cycle counts as zero, so a stale count never lets a one-cycle pulse through
	assign changed = raw != raw_prev;
	assign elapsed = changed ? `ZERO16 : since_edge;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_prev <= 1'b0;
			since_edge <= `ZERO16;
		end else begin
			raw_prev <= raw;
			if (changed)
				since_edge <= `ONE16;
			else if (since_edge != 16'hFFFF)
				since_edge <= since_edge + `ONE16;
		end
	end

	always @* begin
		delay_high = dead_time;
		delay_low = alt_dead_time;
		// Polarity only matters in compensation mode
		if (mode == `DTM_COMP) begin
			delay_high = shorten_high ? sum[15:0] : reduced;
			delay_low = shorten_high ? reduced : sum[15:0];
			if (sum[16] && shorten_high)
				delay_high = 16'hFFFF;
			if (sum[16] && !shorten_high)
				delay_low = 16'hFFFF;
		end
		case (mode)
			`DTM_POSITIVE, `DTM_COMP: begin
				next_high = raw && (elapsed >= delay_high);
				next_low = !raw && (elapsed >= delay_low);
			end
			`DTM_NEGATIVE: begin
				// Overlap: each output is held past its falling edge
				next_high = raw || (elapsed < delay_high);
				next_low = !raw || (elapsed < delay_low);
			end
			`DTM_OFF: begin
				next_high = raw;
				next_low = !raw;
			end
			default: begin
				next_high = 1'b0;
				next_low = 1'b0;
			end
		endcase
		if (!run) begin
			next_high = 1'b0;
			next_low = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_high <= 1'b0;
			out_low <= 1'b0;
		end else begin
			out_high <= next_high;
			out_low <= next_low;
		end
	end
endmodule // pwm_dead_time
`default_nettype wire

// ### pwm_generator_control.v
// Purpose: One PWM generator channel with APB registers and interrupt
// Assumes: APB4 slave, no wait states; time-base ticks synchronous to pclk
// Notes: buffered values move to active copies per the update setting
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module pwm_generator_control (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Master time bases
	input wire primary_tick,
	input wire primary_sync,
	input wire secondary_present,
	input wire secondary_tick,
	input wire secondary_sync,
	// Analog side inputs
	input wire current_limit,
	input wire comp_input,
	// Output pins
	output wire out_high,
	output wire out_low,
	// Interrupt
	output reg irq
);
	// Software-visible registers and the active copies
	reg [15:0] pwm_channel_control;
	reg [15:0] misc_config;
	reg [15:0] shadow [0:`NUM_VALUES-1];
	reg [15:0] active [0:`NUM_VALUES-1];
	reg [`IRQ_W-1:0] irq_status;
	reg [`IRQ_W-1:0] irq_mask;

	// Internal state
	reg limit_prev;
	reg [31:0] next_prdata;
	reg next_slverr;
	reg addr_hit;

	wire [15:0] count;
	wire counting_down;
	wire boundary;

	// Decoded fields
	wire immediate_update_en;
	wire ext_period_reset_en;
	wire center_align_en;
	wire time_base_select;
	wire comp_polarity;
	wire [1:0] dead_time_mode;
	wire pwm_module_on;
	wire independent_time_base;
	wire current_limit_mode;

	// Bus qualifiers
	wire setup_phase;
	wire write_done;
	wire [15:0] wr_ctl;
	wire [15:0] wr_cfg;

	// Time-base steering
	wire sel_tick;
	wire sel_sync;
	wire limit_edge;
	wire ext_reset;
	wire restart;
	wire center_eff;
	wire [15:0] duty;
	wire raw;
	wire update_now;

	// Per-value write strobes
	wire [`NUM_VALUES-1:0] value_we;

	assign immediate_update_en = pwm_channel_control[`CTL_IUE];
	assign ext_period_reset_en = pwm_channel_control[`CTL_EXT_PERIOD_RESET_EN];
	assign center_align_en = pwm_channel_control[`CTL_CAM];
	assign time_base_select = pwm_channel_control[`CTL_TBS];
	assign comp_polarity = pwm_channel_control[`CTL_POL];
	assign dead_time_mode = pwm_channel_control[`CTL_DTM_HI:`CTL_DTM_LO];
	assign pwm_module_on = misc_config[`CFG_ON];
	assign independent_time_base = misc_config[`CFG_ITB];
	assign current_limit_mode = misc_config[`CFG_CURRENT_LIMIT_MODE];

	// Byte-lane merge for the 16-bit registers; upper lanes have no storage
	function [15:0] merge;
		input [15:0] old;
		input [31:0] wdata;
		input [3:0] strb;
		begin
			merge = old;
			if (strb[0])
				merge[7:0] = wdata[7:0];
			if (strb[1])
				merge[15:8] = wdata[15:8];
		end
	endfunction

	// A write lands only at the edge where the access phase sees pready
	assign setup_phase = psel && !penable;
	assign write_done = psel && penable && pready && pwrite && !pslverr;

	assign wr_ctl = merge(pwm_channel_control, pwdata, pstrb) & `CTL_WMASK;
	assign wr_cfg = merge(misc_config, pwdata, pstrb) & `CFG_WMASK;

	// Decode and read mux, evaluated in the setup phase
	always @* begin
		next_prdata = `ZERO32;
		addr_hit = 1'b1;
		case (paddr)
			`OFS_CONTROL: next_prdata[15:0] = pwm_channel_control;
			`OFS_CONFIG: next_prdata[15:0] = misc_config;
			`OFS_PERIOD: next_prdata[15:0] = shadow[`IDX_PERIOD];
			`OFS_MASTER_DUTY: next_prdata[15:0] = shadow[`IDX_MASTER_DUTY];
			`OFS_CHANNEL_DUTY: next_prdata[15:0] = shadow[`IDX_CHANNEL_DUTY];
			`OFS_DEAD_TIME: next_prdata[15:0] = shadow[`IDX_DEAD_TIME];
			`OFS_ALT_DEAD_TIME: next_prdata[15:0] = shadow[`IDX_ALT_DEAD_TIME];
			`OFS_PHASE: next_prdata[15:0] = shadow[`IDX_PHASE];
			`OFS_IRQ_STATUS: next_prdata[`IRQ_W-1:0] = irq_status;
			`OFS_IRQ_MASK: next_prdata[`IRQ_W-1:0] = irq_mask;
			`OFS_COUNT: next_prdata[16:0] = {counting_down, count};
			default: addr_hit = 1'b0;
		endcase
		// The count register is read-only
		next_slverr = !addr_hit || (pwrite && paddr == `OFS_COUNT);
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ZERO32;
		end else begin
			pready <= setup_phase;
			if (setup_phase) begin
				pslverr <= next_slverr;
				prdata <= (pwrite || next_slverr) ? `ZERO32 : next_prdata;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Control and configuration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_channel_control <= `CTL_RESET;
			misc_config <= `ZERO16;
			irq_mask <= {`IRQ_W{1'b0}};
		end else if (write_done) begin
			case (paddr)
				`OFS_CONTROL: pwm_channel_control <= wr_ctl;
				`OFS_CONFIG: misc_config <= wr_cfg;
				`OFS_IRQ_MASK: if (pstrb[0])
					irq_mask <= pwdata[`IRQ_W-1:0];
				default: misc_config <= misc_config;
			endcase
		end
	end

	// Buffered values and their active copies
	assign value_we[`IDX_PERIOD] = write_done && paddr == `OFS_PERIOD;
	assign value_we[`IDX_MASTER_DUTY] = write_done && paddr == `OFS_MASTER_DUTY;
	assign value_we[`IDX_CHANNEL_DUTY] = write_done && paddr == `OFS_CHANNEL_DUTY;
	assign value_we[`IDX_DEAD_TIME] = write_done && paddr == `OFS_DEAD_TIME;
	assign value_we[`IDX_ALT_DEAD_TIME] = write_done && paddr == `OFS_ALT_DEAD_TIME;
	assign value_we[`IDX_PHASE] = write_done && paddr == `OFS_PHASE;

	// Stopped channels load freely so the first period starts on fresh values
	assign update_now = immediate_update_en || boundary || !pwm_module_on;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_VALUES; gi = gi + 1) begin : g_value
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					shadow[gi] <= `ZERO16;
					active[gi] <= `ZERO16;
				end else begin
					if (value_we[gi])
						shadow[gi] <= merge(shadow[gi], pwdata, pstrb);
					if (update_now)
						active[gi] <= shadow[gi];
				end
			end
		end
	endgenerate

	// Time-base source: secondary only when asked for and present
	assign sel_tick = (time_base_select && secondary_present) ? secondary_tick
		: primary_tick;
	assign sel_sync = (time_base_select && secondary_present) ? secondary_sync
		: primary_sync;

	// Current-limit reset; input taken as synchronous, rising edge acts
	assign limit_edge = current_limit && !limit_prev;
	assign ext_reset = limit_edge && ext_period_reset_en
		&& independent_time_base && !current_limit_mode;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			limit_prev <= 1'b0;
		else
			limit_prev <= current_limit;
	end

	// Master mode follows the selected sync; independent mode only the limit
	assign restart = independent_time_base ? ext_reset : sel_sync;
	assign center_eff = center_align_en && independent_time_base;

	pwm_time_base u_time_base (
		.pclk(pclk),
		.presetn(presetn),
		.run(pwm_module_on),
		.tick(sel_tick),
		.restart(restart),
		.center(center_eff),
		.period(active[`IDX_PERIOD]),
		.phase(active[`IDX_PHASE]),
		.count(count),
		.down(counting_down),
		.boundary(boundary)
	);

	// Master duty is shared across channels on the master base
	assign duty = independent_time_base ? active[`IDX_CHANNEL_DUTY]
		: active[`IDX_MASTER_DUTY];
	assign raw = pwm_module_on && (count < duty);

	pwm_dead_time u_dead_time (
		.pclk(pclk),
		.presetn(presetn),
		.run(pwm_module_on),
		.raw(raw),
		.mode(dead_time_mode),
		.polarity(comp_polarity),
		.comp_input(comp_input),
		.dead_time(active[`IDX_DEAD_TIME]),
		.alt_dead_time(active[`IDX_ALT_DEAD_TIME]),
		.out_high(out_high),
		.out_low(out_low)
	);

	// Sticky events; a new event beats a same-cycle clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {`IRQ_W{1'b0}};
		end else begin
			if (write_done && paddr == `OFS_IRQ_STATUS && pstrb[0])
				irq_status <= (irq_status & ~pwdata[`IRQ_W-1:0])
					| {ext_reset, boundary};
			else
				irq_status <= irq_status | {ext_reset, boundary};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end
endmodule // pwm_generator_control
`default_nettype wire

// ### pwm_ctl_chk_assertions.sv
// Purpose: Port-level checks for the PWM channel block
// Assumes: one pclk domain, APB slave with no wait states
// Notes: mode, enable and mask are tracked from accepted writes
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module pwm_ctl_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic out_high,
	input wire logic out_low,
	input wire logic irq
);
	logic [1:0] mode_seen;
	logic [1:0] mask_seen;
	logic on_seen;
	logic [4:0] quiet;
	wire acc = psel && penable && pready;
	wire wr0 = acc && pwrite && pstrb[0];
	wire cfg_wr = wr0 && (paddr == `OFS_CONTROL || paddr == `OFS_CONFIG);
	// Output checks wait out dead-time transients after any control or config write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_seen <= 2'h0;
			mask_seen <= 2'h0;
			on_seen <= 1'b0;
			quiet <= 5'h00;
		end else begin
			if (wr0 && paddr == `OFS_CONTROL) mode_seen <= pwdata[7:6];
			if (wr0 && paddr == `OFS_CONFIG) on_seen <= pwdata[0];
			if (wr0 && paddr == `OFS_IRQ_MASK) mask_seen <= pwdata[1:0];
			if (cfg_wr) quiet <= 5'h00;
			else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready stuck");
	property p_err_unmapped;
		acc && paddr > `OFS_COUNT |-> pslverr && prdata == `ZERO32;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped accepted");
	property p_count_ro;
		acc && pwrite && paddr == `OFS_COUNT |-> pslverr;
	endproperty
	a_count_ro: assert property (p_count_ro) else $error("count write accepted");
	property p_mapped_ok;
		acc && paddr < `OFS_COUNT && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
	property p_positive_gap;
		on_seen && mode_seen == `DTM_POSITIVE && quiet > 5'h14 |-> !(out_high && out_low);
	endproperty
	a_positive_gap: assert property (p_positive_gap) else $error("pair overlap");
	property p_off_compl;
		on_seen && mode_seen == `DTM_OFF && quiet > 5'h14 |-> out_high != out_low;
	endproperty
	a_off_compl: assert property (p_off_compl) else $error("pair not complementary");
	property p_off_low;
		!on_seen && quiet > 5'h02 |-> !out_high && !out_low;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pins driven while off");
	property p_irq_masked;
		mask_seen == 2'h0 && $past(mask_seen) == 2'h0 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");
endmodule // pwm_ctl_chk
bind pwm_generator_control pwm_ctl_chk u_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.out_high(out_high), .out_low(out_low), .irq(irq));
`default_nettype wire

// ### far_side_model.sv
// Purpose: Master time bases and a power-stage pulse counter
// Assumes: primary steps every cycle, secondary every other cycle
// Notes: counts cover whole periods, so start phase does not matter
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and counter control
	input wire logic clr,
	input wire logic out_high,
	input wire logic out_low,
	// Time bases
	output logic primary_tick,
	output logic secondary_tick,
	// Counts
	output logic [15:0] hi_cnt,
	output logic [15:0] lo_cnt,
	output logic [15:0] rise_cnt
);
	logic last_high;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_tick <= 1'b0;
			secondary_tick <= 1'b0;
			last_high <= 1'b0;
		end else begin
			primary_tick <= 1'b1;
			secondary_tick <= !secondary_tick;
			last_high <= out_high;
		end
	end
	always_ff @(posedge pclk) begin
		if (clr) begin
			hi_cnt <= 16'h0000;
			lo_cnt <= 16'h0000;
			rise_cnt <= 16'h0000;
		end else begin
			hi_cnt <= hi_cnt + {15'h0000, out_high};
			lo_cnt <= lo_cnt + {15'h0000, out_low};
			rise_cnt <= rise_cnt + {15'h0000, out_high && !last_high};
		end
	end
endmodule // far_side_model
`default_nettype wire

// ### test_pwm_generator_control.sv
// Purpose: Register-level bench for the PWM channel block
// Assumes: APB master with bounded waits, ticks from the far-side model
// Notes: widths are summed over whole periods at period 20, duty 8
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"
module test_pwm_generator_control;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic secondary_present = 1'b1;
	logic current_limit = 1'b0;
	logic comp_input = 1'b0;
	logic ssync = 1'b0;
	logic clr = 1'b1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ptick;
	logic stick;
	logic out_high;
	logic out_low;
	logic irq;
	logic [15:0] hi_cnt;
	logic [15:0] lo_cnt;
	logic [15:0] rise_cnt;
	logic [15:0] hc;
	logic [15:0] lc;
	logic [15:0] rc;
	integer failures = 0;
	integer check_count = 0;
	integer i;
	logic [15:0] t_ctl [0:7] = '{16'h0000, 16'h0020, 16'h0040, 16'h0080,
		16'h00c0, 16'h00e0, 16'h00c0, 16'h00e0};
	logic [15:0] t_hi [0:7] = '{16'h0014, 16'h0014, 16'h002c, 16'h0020,
		16'h0010, 16'h0018, 16'h0018, 16'h0010};
	logic [15:0] t_lo [0:7] = '{16'h002c, 16'h002c, 16'h0034, 16'h0030,
		16'h0028, 16'h0020, 16'h0020, 16'h0028};
	logic [7:0] t_cmp = 8'hc2;
	logic [15:0] r_ctl [0:4] = '{16'h0080, 16'h0088, 16'h0088, 16'h0084, 16'h0084};
	logic [15:0] r_cfg [0:4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h0001};
	logic [15:0] r_rise [0:4] = '{16'h0026, 16'h0013, 16'h0026, 16'h0014, 16'h0026};
	logic [4:0] r_sec = 5'h1b;
	logic [15:0] e_ctl [0:3] = '{16'h0082, 16'h0080, 16'h0082, 16'h0082};
	logic [15:0] e_cfg [0:3] = '{16'h0003, 16'h0003, 16'h0007, 16'h0001};
	logic [15:0] e_st [0:3] = '{16'h0003, 16'h0001, 16'h0001, 16'h0001};
	always #5 pclk = ~pclk;
	pwm_generator_control i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_tick(ptick),
		.primary_sync(1'b0), .secondary_present(secondary_present),
		.secondary_tick(stick), .secondary_sync(ssync), .current_limit(current_limit),
		.comp_input(comp_input), .out_high(out_high), .out_low(out_low), .irq(irq));
	far_side_model i_far (.pclk(pclk), .presetn(presetn), .clr(clr), .out_high(out_high),
		.out_low(out_low), .primary_tick(ptick), .secondary_tick(stick),
		.hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .rise_cnt(rise_cnt));
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", check_count, failures);
			if (failures == 0 && check_count > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("BAD %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge pclk);
		end
	endtask
	task xfer(input [11:0] a, input w, input [31:0] d, input [31:0] ed, input ee);
		integer n;
		begin
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			for (n = 0; pready !== 1'b1 && n < 20; n = n + 1)
				@(posedge pclk);
			if (n == 20) begin
				failures = failures + 1;
				complete_run;
			end
			if (!w) chk($sformatf("data %h", a), ed, prdata);
			chk($sformatf("error %h", a), {31'h0000_0000, ee}, {31'h0000_0000, pslverr});
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		xfer(a, 1'b1, d, 32'h0000_0000, 1'b0);
	endtask
	task rd(input [11:0] a, input [31:0] ed);
		xfer(a, 1'b0, 32'h0000_0000, ed, 1'b0);
	endtask
	// Alignment and update bits change only with the module off
	task setup(input [15:0] ctl, input [15:0] cfg, input [15:0] per, input [15:0] duty);
		begin
			wr(`OFS_CONFIG, 32'h0000_0000);
			wr(`OFS_CONTROL, {16'h0000, ctl});
			wr(`OFS_PERIOD, {16'h0000, per});
			wr(`OFS_MASTER_DUTY, {16'h0000, duty});
			wr(`OFS_CHANNEL_DUTY, {16'h0000, duty});
			wr(`OFS_DEAD_TIME, 32'h0000_0003);
			wr(`OFS_ALT_DEAD_TIME, 32'h0000_0001);
			wr(`OFS_IRQ_STATUS, 32'h0000_0003);
			wr(`OFS_CONFIG, {16'h0000, cfg});
		end
	endtask
	task meas(input integer w);
		begin
			clr <= 1'b1;
			@(posedge pclk);
			clr <= 1'b0;
			repeat (w) @(posedge pclk);
			@(negedge pclk);
			hc = hi_cnt;
			lc = lo_cnt;
			rc = rise_cnt;
			@(posedge pclk);
		end
	endtask
	initial begin
		cyc(10);
		presetn <= 1'b1;
		cyc(1);
		rd(`OFS_CONTROL, 32'h0000_0000);
		wr(`OFS_CONTROL, 32'hffff_ffff);
		rd(`OFS_CONTROL, 32'h0000_00ef);
		xfer(12'h030, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
		xfer(`OFS_COUNT, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1);
		$display("test registers done");
		for (i = 0; i < 8; i = i + 1) begin
			comp_input <= t_cmp[i];
			setup(t_ctl[i], 16'h0001, 16'h0013, 16'h0008);
			cyc(60);
			meas(80);
			chk("high width", {16'h0000, t_hi[i]}, {16'h0000, hc});
			chk("low width", {16'h0000, t_lo[i]}, {16'h0000, lc});
			chk("pulses", 32'h0000_0004, {16'h0000, rc});
		end
		$display("test dead time done");
		for (i = 0; i < 5; i = i + 1) begin
			secondary_present <= r_sec[i];
			setup(r_ctl[i], r_cfg[i], 16'h0013, 16'h0008);
			cyc(100);
			meas(760);
			chk("periods", {16'h0000, r_rise[i]}, {16'h0000, rc});
		end
		$display("test time base done");
		rd(`OFS_IRQ_STATUS, 32'h0000_0001);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		wr(`OFS_IRQ_MASK, 32'h0000_0001);
		cyc(2);
		chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
		wr(`OFS_CONFIG, 32'h0000_0000);
		wr(`OFS_IRQ_STATUS, 32'h0000_0001);
		rd(`OFS_IRQ_STATUS, 32'h0000_0000);
		cyc(2);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		$display("test interrupt done");
		for (i = 0; i < 4; i = i + 1) begin
			setup(e_ctl[i], e_cfg[i], 16'h0013, 16'h0008);
			cyc(20);
			current_limit <= 1'b1;
			cyc(3);
			current_limit <= 1'b0;
			cyc(3);
			rd(`OFS_IRQ_STATUS, {16'h0000, e_st[i]});
		end
		$display("test external reset done");
		setup(16'h0080, 16'h0001, 16'h03e8, 16'h0000);
		cyc(10);
		wr(`OFS_MASTER_DUTY, 32'h0000_03e8);
		cyc(5);
		chk("held duty", 32'h0000_0000, {31'h0000_0000, out_high});
		cyc(1000);
		chk("boundary duty", 32'h0000_0001, {31'h0000_0000, out_high});
		setup(16'h0081, 16'h0001, 16'h03e8, 16'h0000);
		cyc(10);
		wr(`OFS_MASTER_DUTY, 32'h0000_03e8);
		cyc(5);
		chk("immediate duty", 32'h0000_0001, {31'h0000_0000, out_high});
		$display("test update done");
		setup(16'h0088, 16'h0001, 16'h0013, 16'h0008);
		wr(`OFS_PHASE, 32'h0000_000a);
		cyc(60);
		ssync <= 1'b1;
		cyc(1);
		ssync <= 1'b0;
		rd(`OFS_COUNT, 32'h0000_000a);
		$display("test sync done");
		complete_run;
	end
endmodule // test_pwm_generator_control
`default_nettype wire
